//--- shared/amre_pkg.sv
// Constants, register map and mode codes for the matching rule evaluator.
// Assumes a 100 MHz core clock and a byte-addressed AXI4-Lite register bus.
package amre_pkg;

  // Rule layer codes.
  typedef enum logic [1:0] {
    LAYER_OFF = 2'b00,
    LAYER_L2  = 2'b01,
    LAYER_L3  = 2'b10,
    LAYER_L4  = 2'b11
  } amre_layer_t;

  // Comparison-select codes per layer.
  localparam logic [1:0] L2_COUNT = 2'h0;
  localparam logic [1:0] L2_TYPE  = 2'h1;
  localparam logic [1:0] L2_MAC   = 2'h2;
  localparam logic [1:0] L2_BOTH  = 2'h3;
  localparam logic [1:0] L3_MASK  = 2'h1;
  localparam logic [1:0] L3_BOTH  = 2'h2;
  localparam logic [1:0] L4_PROTO = 2'h0;
  localparam logic [1:0] L4_TCP   = 2'h1;
  localparam logic [1:0] L4_UDP   = 2'h2;
  localparam logic [1:0] L4_SEQ   = 2'h3;

  // Port range check codes.
  localparam logic [1:0] PC_OFF    = 2'h0;
  localparam logic [1:0] PC_EITHER = 2'h1;
  localparam logic [1:0] PC_IN     = 2'h2;
  localparam logic [1:0] PC_OUT    = 2'h3;

  // Register word indices; byte address is index times four.
  localparam logic [5:0] IDX_CTRL   = 6'h00;
  localparam logic [5:0] IDX_MACLO  = 6'h01;
  localparam logic [5:0] IDX_MACHI  = 6'h02;
  localparam logic [5:0] IDX_IPADDR = 6'h03;
  localparam logic [5:0] IDX_IPMASK = 6'h04;
  localparam logic [5:0] IDX_PORTS  = 6'h05;
  localparam logic [5:0] IDX_FLAGS  = 6'h06;
  localparam logic [5:0] IDX_ACTION = 6'h07;
  localparam logic [5:0] IDX_MSET   = 6'h08;
  localparam logic [5:0] IDX_STATUS = 6'h09;
  localparam logic [5:0] IDX_IRQST  = 6'h0A;
  localparam logic [5:0] IDX_IRQMSK = 6'h0B;
  localparam int         NUM_REGS   = 12;
  localparam logic [31:0] REG_RST   = 32'h0000_0000;

  // Field positions.
  localparam int CTRL_LAYER = 0;
  localparam int CTRL_CSEL  = 2;
  localparam int CTRL_SIDE  = 4;
  localparam int CTRL_POL   = 5;
  localparam int CTRL_PRC   = 6;
  localparam int CTRL_FLAG  = 8;
  localparam int CTRL_KIND  = 16;
  localparam int MACHI_TYPE = 16;
  localparam int PORTS_MAX  = 16;
  localparam int FLAGS_IGN  = 8;
  localparam int ACT_TB     = 11;
  localparam int ACT_ALG    = 12;
  localparam int STAT_ENTRY = 1;
  localparam int STAT_CNT   = 16;

  // Sizes.
  localparam int NUM_RULES = 16;
  localparam int PORTS     = 6;
  localparam int CNT_W     = 11;

  // Timebase: microsecond from clock cycles, millisecond from microseconds.
  localparam int       CLK_NS    = 10;
  localparam int       US_NS     = 1000;
  localparam int       US_CYC    = (US_NS + CLK_NS - 1) / CLK_NS;
  localparam int       MS_US     = 1000;
  localparam logic [6:0] US_LAST = 7'(US_CYC - 1);
  localparam logic [9:0] MS_LAST = 10'(MS_US - 1);

  // AXI responses.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- hdl/amre_acl_matching_rule_evaluator.sv
// One access-control matching rule, its count mode and an AXI4-Lite slave.
// Assumes parsed header fields arrive with a one-cycle frame strobe on clk.
//
// Behaviour
// (R1) Layer and comparison select steer the rule.
// (R2) Layer off means no comparison, no match.
// (R3) L2 select 01 compares EtherType only.
// (R4) L2 10 compares MAC, 11 both.
// (R5) Side bit: 0 destination, 1 source.
// (R6) Polarity 1 equal true, 0 unequal true.
// (R7) L2 rule holds MAC and EtherType values.
// (R8) Count mode tests both, takes 11-bit count.
// (R9) Timebase 0 microseconds, 1 milliseconds.
// (R10) Algorithm 0 reloads, counts down, fires on expiry.
// (R11) Algorithm 1 counts packets, fires, then clears.
// (R12) L3 select 01 masked single address compare.
// (R13) L3 select 10 both addresses unmasked.
// (R14) Mask bit 1 ignores that address bit.
// (R15) Software avoids reserved L3 selects.
// (R16) L4 select: protocol, TCP, UDP, sequence.
// (R17) Port bounds double as sequence number.
// (R18) Port check: off, either, inside, outside.
// (R19) Protocol compare against 8-bit value.
// (R20) Flag enable gates TCP flag compare.
// (R21) Flag ignore bit 1 skips that flag.
// (R22) Entry match ANDs all selected rules.
// (R23) Count events set per-port masked status.
// (R24) Evaluate once per frame before forwarding.
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ps

module amre_acl_matching_rule_evaluator #(
  parameter int RULE_INDEX = 0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        frameValid,
  input  wire logic [2:0]  ingressPort,
  input  wire logic [47:0] dstMac,
  input  wire logic [47:0] srcMac,
  input  wire logic [15:0] etherType,
  input  wire logic        isIpv4,
  input  wire logic [31:0] srcIp,
  input  wire logic [31:0] dstIp,
  input  wire logic [7:0]  ipProto,
  input  wire logic        isTcp,
  input  wire logic        isUdp,
  input  wire logic [15:0] srcPort,
  input  wire logic [15:0] dstPort,
  input  wire logic [31:0] tcpSeq,
  input  wire logic [7:0]  tcpFlags,
  input  wire logic [15:0] otherMatches,
  output logic             matchValid,
  output logic             ruleMatch,
  output logic             entryMatch,
  output logic             countIrq
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode helpers.

  // A word is mapped when aligned and within the register range.
  function automatic logic isMapped(input logic [7:0] a);
    isMapped = (a[1:0] == 2'h0) && (a[7:2] < 6'(amre_pkg::NUM_REGS));
  endfunction

  // Merges a write word into a register under byte strobes.
  function automatic logic [31:0] mergeStrb(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    end
    mergeStrb = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write and read channels.

  logic        awHave_q, awHave_d, wHave_q, wHave_d;
  logic        awready_q, awready_d, wready_q, wready_d;
  logic        bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic        arready_q, arready_d;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q, rdata_q, readWord;
  logic [3:0]  wStrb_q;
  logic [1:0]  bresp_q, rresp_q;
  logic        awTake, wTake, arTake, wrEn, wrOk;
  logic [5:0]  wrIdx, rdIdx;

  // Handshake terms; the write fires once both halves are held.
  assign awTake    = awvalid & awready_q;
  assign wTake     = wvalid & wready_q;
  assign arTake    = arvalid & arready_q;
  assign wrEn      = awHave_q & wHave_q & ~bvalid_q;
  assign wrOk      = isMapped(awAddr_q);
  assign wrIdx     = awAddr_q[7:2];
  assign rdIdx     = araddr[7:2];
  assign awHave_d  = (awHave_q | awTake) & ~wrEn;
  assign wHave_d   = (wHave_q | wTake) & ~wrEn;
  assign bvalid_d  = wrEn | (bvalid_q & ~bready);
  assign awready_d = ~awHave_d & ~bvalid_d;
  assign wready_d  = ~wHave_d & ~bvalid_d;
  assign rvalid_d  = arTake | (rvalid_q & ~rready);
  assign arready_d = ~rvalid_d;

  // Channel state and captured payloads.
  always_ff @(posedge clk) begin
    if (rst) begin
      awHave_q  <= 1'b0;
      wHave_q   <= 1'b0;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      arready_q <= 1'b0;
      awAddr_q  <= 8'h00;
      wData_q   <= amre_pkg::REG_RST;
      wStrb_q   <= 4'h0;
      bresp_q   <= amre_pkg::RESP_OKAY;
      rresp_q   <= amre_pkg::RESP_OKAY;
      rdata_q   <= amre_pkg::REG_RST;
    end else begin
      awHave_q  <= awHave_d;
      wHave_q   <= wHave_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      bvalid_q  <= bvalid_d;
      rvalid_q  <= rvalid_d;
      arready_q <= arready_d;
      if (awTake) awAddr_q <= awaddr;
      if (wTake) wData_q <= wdata;
      if (wTake) wStrb_q <= wstrb;
      if (wrEn) bresp_q <= wrOk ? amre_pkg::RESP_OKAY : amre_pkg::RESP_SLVERR;
      if (arTake) rresp_q <= isMapped(araddr) ? amre_pkg::RESP_OKAY : amre_pkg::RESP_SLVERR;
      if (arTake) rdata_q <= readWord;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file.

  logic [31:0] cfg_q [amre_pkg::NUM_REGS];
  logic [amre_pkg::PORTS-1:0] irqSt_q, irqSt_d, w1c, fireVec;
  logic [31:0] statusWord;

  // Writable words take strobed data; status words are not stored here.
  always_ff @(posedge clk) begin
    for (int i = 0; i < amre_pkg::NUM_REGS; i++) begin
      if (rst) begin
        cfg_q[i] <= amre_pkg::REG_RST;
      end else if (wrEn && wrOk && wrIdx == 6'(i) && wrIdx != amre_pkg::IDX_STATUS
                   && wrIdx != amre_pkg::IDX_IRQST) begin
        cfg_q[i] <= mergeStrb(cfg_q[i], wData_q, wStrb_q);
      end
    end
  end

  // Read selection; unmapped words read zero with an error response.
  always_comb begin
    readWord = amre_pkg::REG_RST;
    if (!isMapped(araddr)) readWord = amre_pkg::REG_RST;
    else if (rdIdx == amre_pkg::IDX_STATUS) readWord = statusWord;
    else if (rdIdx == amre_pkg::IDX_IRQST) readWord = 32'(irqSt_q);
    else readWord = cfg_q[rdIdx[3:0]];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rule fields.

  logic [31:0] ctrl, ports, flags, action;
  amre_pkg::amre_layer_t layerSel;
  logic [1:0]  csel, prc;
  logic        side, pol, flagOn, timebase, algo;
  logic [47:0] ruleMac, frameMac;
  logic [15:0] ruleType, portMin, portMax, framePort;
  logic [31:0] ipAddr, ipMask, frameIp;
  logic [7:0]  kind, flagVal, flagIgn;
  logic [amre_pkg::CNT_W-1:0] countVal;
  logic [15:0] mset;

  // Field slices of the stored words; port bounds share the sequence word.
  assign ctrl     = cfg_q[amre_pkg::IDX_CTRL[3:0]];
  assign ports    = cfg_q[amre_pkg::IDX_PORTS[3:0]]; // [R17]
  assign flags    = cfg_q[amre_pkg::IDX_FLAGS[3:0]];
  assign action   = cfg_q[amre_pkg::IDX_ACTION[3:0]];
  assign layerSel = amre_pkg::amre_layer_t'(ctrl[amre_pkg::CTRL_LAYER +: 2]);
  assign csel     = ctrl[amre_pkg::CTRL_CSEL +: 2];
  assign side     = ctrl[amre_pkg::CTRL_SIDE];
  assign pol      = ctrl[amre_pkg::CTRL_POL];
  assign prc      = ctrl[amre_pkg::CTRL_PRC +: 2];
  assign flagOn   = ctrl[amre_pkg::CTRL_FLAG];
  assign kind     = ctrl[amre_pkg::CTRL_KIND +: 8];
  assign ruleMac  = {cfg_q[amre_pkg::IDX_MACHI[3:0]][15:0], cfg_q[amre_pkg::IDX_MACLO[3:0]]}; // [R7]
  assign ruleType = cfg_q[amre_pkg::IDX_MACHI[3:0]][amre_pkg::MACHI_TYPE +: 16]; // [R7]
  assign ipAddr   = cfg_q[amre_pkg::IDX_IPADDR[3:0]];
  assign ipMask   = cfg_q[amre_pkg::IDX_IPMASK[3:0]];
  assign portMin  = ports[15:0];
  assign portMax  = ports[amre_pkg::PORTS_MAX +: 16];
  assign flagVal  = flags[7:0];
  assign flagIgn  = flags[amre_pkg::FLAGS_IGN +: 8];
  assign countVal = action[amre_pkg::CNT_W-1:0]; // [R8]
  assign timebase = action[amre_pkg::ACT_TB];
  assign algo     = action[amre_pkg::ACT_ALG];
  assign mset     = cfg_q[amre_pkg::IDX_MSET[3:0]][15:0];

  ////////////////////////////////////////////////////////////////////////////
  // Header comparisons.

  logic macEq, typeEq, ipMaskEq, ipBothEq, portHit, flagHit, cmpEq, cmpLegal, ruleTrue;

  // Side bit picks the header field under test.
  assign frameMac  = side ? srcMac : dstMac; // [R5]
  assign frameIp   = side ? srcIp : dstIp; // [R5]
  assign framePort = side ? srcPort : dstPort; // [R5]
  assign macEq     = frameMac == ruleMac;
  assign typeEq    = etherType == ruleType;
  assign ipMaskEq  = isIpv4 && (((frameIp ^ ipAddr) & ~ipMask) == 32'h0000_0000); // [R14]
  assign ipBothEq  = isIpv4 && srcIp == ipAddr && dstIp == ipMask; // [R13]
  assign flagHit   = !flagOn || (((tcpFlags ^ flagVal) & ~flagIgn) == 8'h00); // [R20] [R21]

  // Port check selects which bound relation counts as a hit.
  always_comb begin
    unique case (prc)
      amre_pkg::PC_OFF:    portHit = 1'b1;
      amre_pkg::PC_EITHER: portHit = framePort == portMin || framePort == portMax; // [R18]
      amre_pkg::PC_IN:     portHit = framePort >= portMin && framePort <= portMax; // [R18]
      amre_pkg::PC_OUT:    portHit = framePort < portMin || framePort > portMax; // [R18]
    endcase
  end

  // Layer and select pick the equality; reserved codes never match.
  always_comb begin
    cmpEq    = 1'b0;
    cmpLegal = 1'b1;
    unique case (layerSel) // [R1]
      amre_pkg::LAYER_OFF: cmpLegal = 1'b0; // [R2]
      amre_pkg::LAYER_L2: begin
        unique case (csel)
          amre_pkg::L2_TYPE: cmpEq = typeEq; // [R3]
          amre_pkg::L2_MAC:  cmpEq = macEq; // [R4]
          default:           cmpEq = macEq && typeEq; // [R4] [R8]
        endcase
      end
      amre_pkg::LAYER_L3: begin
        cmpLegal = csel == amre_pkg::L3_MASK || csel == amre_pkg::L3_BOTH; // [R15]
        cmpEq    = (csel == amre_pkg::L3_MASK) ? ipMaskEq : ipBothEq; // [R12]
      end
      amre_pkg::LAYER_L4: begin
        unique case (csel) // [R16]
          amre_pkg::L4_PROTO: cmpEq = isIpv4 && ipProto == kind; // [R19]
          amre_pkg::L4_TCP:   cmpEq = isTcp && portHit && flagHit;
          amre_pkg::L4_UDP:   cmpEq = isUdp && portHit;
          amre_pkg::L4_SEQ:   cmpEq = isTcp && tcpSeq == ports && flagHit; // [R17]
        endcase
      end
    endcase
  end

  // Polarity turns equality into the rule result.
  assign ruleTrue = cmpLegal && (pol ? cmpEq : !cmpEq); // [R6]

  ////////////////////////////////////////////////////////////////////////////
  // Entry result across the selected rule set.

  logic [15:0] matchVec;
  logic        entryNow, matchValid_q, ruleMatch_q, entryMatch_q;

  // This rule's bit replaces its slot in the vector from sibling rules.
  always_comb begin
    matchVec             = otherMatches;
    matchVec[RULE_INDEX] = ruleTrue;
  end
  assign entryNow = &(~mset | matchVec); // [R22]

  // One evaluation per frame strobe, held until the next frame.
  always_ff @(posedge clk) begin
    if (rst) begin
      matchValid_q <= 1'b0;
      ruleMatch_q  <= 1'b0;
      entryMatch_q <= 1'b0;
    end else begin
      matchValid_q <= frameValid; // [R24]
      if (frameValid) ruleMatch_q <= ruleTrue; // [R24]
      if (frameValid) entryMatch_q <= entryNow; // [R22]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Count mode timebase and counter.

  logic [6:0] usCnt_q;
  logic [9:0] msCnt_q;
  logic       usTick, msTick, unitTick, countMode, qual, fire, armed_q, armed_d;
  logic [amre_pkg::CNT_W-1:0] cnt_q, cnt_d, cntInc;
  logic [2:0] lastPort_q, firePort;

  // Microsecond ticks from cycles, millisecond ticks from microseconds.
  assign usTick   = usCnt_q == amre_pkg::US_LAST;
  assign msTick   = usTick && msCnt_q == amre_pkg::MS_LAST;
  assign unitTick = timebase ? msTick : usTick; // [R9]
  assign countMode = layerSel == amre_pkg::LAYER_L2 && csel == amre_pkg::L2_COUNT; // [R8]
  assign qual     = frameValid && countMode && ruleTrue;
  assign cntInc   = cnt_q + 11'h001;

  // Algorithm 0 watches the gap between packets, algorithm 1 counts them.
  always_comb begin
    cnt_d   = cnt_q;
    armed_d = armed_q;
    fire    = 1'b0;
    if (!countMode) begin
      cnt_d   = 11'h000;
      armed_d = 1'b0;
    end else if (!algo) begin
      if (qual) begin
        cnt_d   = countVal; // [R10]
        armed_d = 1'b1;
      end else if (armed_q && unitTick) begin
        if (cnt_q <= 11'h001) begin
          cnt_d   = 11'h000;
          armed_d = 1'b0;
          fire    = 1'b1; // [R10]
        end else begin
          cnt_d = cnt_q - 11'h001; // [R10]
        end
      end
    end else if (qual) begin
      fire  = cntInc == countVal; // [R11]
      cnt_d = fire ? 11'h000 : cntInc; // [R11]
    end
  end

  // Expiry belongs to the port of the last qualifying packet.
  assign firePort = (algo && qual) ? ingressPort : lastPort_q;
  assign fireVec  = fire ? (amre_pkg::PORTS'(1) << firePort) : '0;
  assign w1c      = (wrEn && wrOk && wrIdx == amre_pkg::IDX_IRQST && wStrb_q[0]) ? wData_q[amre_pkg::PORTS-1:0] : '0;
  assign irqSt_d  = (irqSt_q & ~w1c) | fireVec; // [R23]

  // Timebase, counter, sticky per-port status and masked interrupt.
  always_ff @(posedge clk) begin
    if (rst) begin
      usCnt_q    <= 7'h00;
      msCnt_q    <= 10'h000;
      cnt_q      <= 11'h000;
      armed_q    <= 1'b0;
      lastPort_q <= 3'h0;
      irqSt_q    <= '0;
      countIrq   <= 1'b0;
    end else begin
      usCnt_q    <= usTick ? 7'h00 : usCnt_q + 7'h01;
      if (usTick) msCnt_q <= msTick ? 10'h000 : msCnt_q + 10'h001;
      cnt_q      <= cnt_d;
      armed_q    <= armed_d;
      if (qual) lastPort_q <= ingressPort;
      irqSt_q    <= irqSt_d;
      countIrq   <= |(irqSt_d & cfg_q[amre_pkg::IDX_IRQMSK[3:0]][amre_pkg::PORTS-1:0]); // [R23]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs and status word.

  assign statusWord = (32'(cnt_q) << amre_pkg::STAT_CNT) | (32'(entryMatch_q) << amre_pkg::STAT_ENTRY)
                      | 32'(ruleMatch_q);
  assign awready    = awready_q;
  assign wready     = wready_q;
  assign bvalid     = bvalid_q;
  assign bresp      = bresp_q;
  assign arready    = arready_q;
  assign rvalid     = rvalid_q;
  assign rdata      = rdata_q;
  assign rresp      = rresp_q;
  assign matchValid = matchValid_q;
  assign ruleMatch  = ruleMatch_q;
  assign entryMatch = entryMatch_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // A qualifying packet under algorithm 0 in count mode.
  sequence seqReload;
    qual && !algo;
  endsequence

  a_disabled_nomatch: assert property (frameValid && layerSel == amre_pkg::LAYER_OFF |=> matchValid && !ruleMatch) // [R2]
    else $error("disabled rule matched");
  a_type_polarity: assert property (frameValid && layerSel == amre_pkg::LAYER_L2 && csel == amre_pkg::L2_TYPE
    |=> ruleMatch == ($past(etherType == ruleType) == $past(pol))) // [R3]
    else $error("ethertype compare or polarity wrong");
  a_l3_reserved: assert property (frameValid && layerSel == amre_pkg::LAYER_L3 && csel == amre_pkg::L4_SEQ
    |=> !ruleMatch) // [R15]
    else $error("reserved layer 3 select matched");
  a_entry_and: assert property (matchValid && mset[RULE_INDEX] && !ruleMatch |-> !entryMatch) // [R22]
    else $error("entry matched with a false rule");
  a_timer_reload: assert property (seqReload |=> armed_q && cnt_q == $past(countVal)) // [R10]
    else $error("timer not reloaded");
  a_count_step: assert property (qual && algo && cntInc != countVal |=> cnt_q == $past(cntInc)) // [R11]
    else $error("packet count not advanced");
  a_us_spacing: assert property (usTick |=> !usTick [*8]) // [R9]
    else $error("microsecond ticks too close");
  a_fire_sticky: assert property (fire && firePort < 3'(amre_pkg::PORTS) |=> irqSt_q != '0 ##1 1'b1) // [R23]
    else $error("count event lost");
  a_proto_cmp: assert property (frameValid && layerSel == amre_pkg::LAYER_L4 && csel == amre_pkg::L4_PROTO
    && isIpv4 && ipProto == kind && pol |=> ruleMatch) // [R19]
    else $error("protocol compare missed");

endmodule // amre_acl_matching_rule_evaluator

//--- verif/amre_far_model.sv
// Frame source standing in for the switch ingress header parser.
// Assumes the bench calls send and that clk is the evaluator's clock.
`timescale 1ns/1ps
module amre_far_model (
  input  wire logic clk,
  output logic      frameValid,
  output logic [2:0]  ingressPort,
  output logic [47:0] dstMac,
  output logic [47:0] srcMac,
  output logic [15:0] etherType,
  output logic        isIpv4,
  output logic [31:0] srcIp,
  output logic [31:0] dstIp,
  output logic [7:0]  ipProto,
  output logic        isTcp,
  output logic        isUdp,
  output logic [15:0] srcPort,
  output logic [15:0] dstPort,
  output logic [31:0] tcpSeq,
  output logic [7:0]  tcpFlags
);
  logic         busy = 1'b0;
  logic [260:0] hdr;

  // All header lines come from one vector, cleared at start.
  assign {dstMac, srcMac, etherType, srcIp, dstIp, ipProto, srcPort, dstPort, tcpSeq, tcpFlags,
          isIpv4, isTcp, isUdp, ingressPort} = hdr;
  initial {frameValid, hdr} = '0;

  // Idle header lines flip each cycle, so stale values are never trusted.
  always @(posedge clk) begin
    if (!busy && !frameValid) hdr <= ~hdr;
  end

  // One frame: source fields invert destination fields; k is ipv4, tcp, udp.
  task automatic send(input logic [47:0] m, input logic [15:0] e, input logic [31:0] a,
                      input logic [15:0] p, input logic [7:0] f, input logic [2:0] k, input logic [2:0] n);
    busy = 1'b1;
    @(posedge clk);
    hdr <= {m, ~m, e, ~a, a, (k[1] ? 8'h06 : 8'h11), ~p, p, p, p, f, k, n};
    frameValid <= 1'b1;
    @(posedge clk);
    frameValid <= 1'b0;
    busy = 1'b0;
  endtask
endmodule // amre_far_model

//--- verif/amre_acl_matching_rule_evaluator_tb.sv
// Self-checking bench for the matching rule evaluator.
// Assumes the far-side frame model and a synchronous active-high reset.
`timescale 1ns/1ps
module amre_acl_matching_rule_evaluator_tb;
  localparam logic [47:0] M = 48'h0012_3456_789A;
  localparam logic [15:0] T = 16'h88B5;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  localparam logic [15:0] S = 16'h0003;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata;
  logic [3:0]  wstrb = 4'hF;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [15:0] otherMatches;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata, srcIp, dstIp, tcpSeq;
  logic        awready, wready, bvalid, arready, rvalid, matchValid, ruleMatch, entryMatch, countIrq;
  logic        frameValid, isIpv4, isTcp, isUdp;
  logic [2:0]  ingressPort;
  logic [47:0] dstMac, srcMac;
  logic [15:0] etherType, srcPort, dstPort;
  logic [7:0]  ipProto, tcpFlags;
  logic [1:0]  fq[$];
  logic [33:0] rq[$];
  int          badCount = 0;
  int          checkCount = 0;
  int          cycles = 0;
  integer      seed = 4;

  amre_acl_matching_rule_evaluator i_dut (
    .clk, .rst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .frameValid, .ingressPort,
    .dstMac, .srcMac, .etherType, .isIpv4, .srcIp, .dstIp, .ipProto, .isTcp, .isUdp, .srcPort,
    .dstPort, .tcpSeq, .tcpFlags, .otherMatches, .matchValid, .ruleMatch, .entryMatch, .countIrq);
  amre_far_model i_far (
    .clk, .frameValid, .ingressPort, .dstMac, .srcMac, .etherType, .isIpv4, .srcIp, .dstIp,
    .ipProto, .isTcp, .isUdp, .srcPort, .dstPort, .tcpSeq, .tcpFlags);

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Compare, verdict and bus tasks.
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic endSim();
    if (badCount == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [5:0] idx, input logic [31:0] d);
    {awaddr, wdata, awvalid, wvalid, bready} <= {idx, 2'b00, d, 3'b111};
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
  endtask

  // Notes the expected answer, then reads.
  task automatic rd(input logic [5:0] idx, input logic [33:0] exp);
    rq.push_back(exp);
    {araddr, arvalid, rready} <= {idx, 2'b00, 2'b11};
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
  endtask

  // One frame with random sibling results; notes the expected outcome.
  task automatic fr(input logic [47:0] m, input logic [15:0] e, input logic [31:0] a, input logic [15:0] p,
                    input logic [7:0] f, input logic [2:0] k, input logic [2:0] n, input logic x);
    logic [15:0] om;
    om = 16'($random(seed));
    otherMatches <= om;
    fq.push_back({x, &(~S | {om[15:1], x})});
    i_far.send(m, e, a, p, f, k, n);
  endtask

  task automatic l2(input logic [47:0] m, input logic [15:0] e, input logic [2:0] n, input logic x);
    fr(m, e, 32'h0, 16'h0, 8'h00, 3'b000, n, x);
  endtask

  task automatic l3(input logic [31:0] a, input logic x);
    fr(48'h0, 16'h0800, a, 16'h0, 8'h00, 3'b100, 3'h0, x);
  endtask

  task automatic l4(input logic [15:0] p, input logic [7:0] f, input logic [2:0] k, input logic x);
    fr(48'h0, 16'h0800, 32'h0, p, f, k, 3'h1, x);
  endtask

  // Control word: layer, select, side, polarity, port check, flag enable, protocol 06.
  task automatic cw(input logic [1:0] ly, cs, input logic sd, pl, input logic [1:0] pc, input logic fl);
    wr(amre_pkg::IDX_CTRL, {8'h00, 8'h06, 7'h00, fl, pc, pl, sd, cs, ly});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Compares each result with its oldest note; ends a hung run.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (matchValid && fq.size() > 0) check({32'h0, ruleMatch, entryMatch}, {32'h0, fq.pop_front()});
    if (rvalid && rready && rq.size() > 0) check({rresp, rdata}, rq.pop_front());
    if (cycles == 6000) begin
      badCount++;
      endSim();
    end
  end

  // Main sequence.
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rd(6'h00, 34'h0);
    rd(6'h0C, {2'h2, 32'h0});
    wr(6'h08, {16'h0000, S});
    wr(6'h01, 32'h3456_789A);
    wr(6'h02, {T, 16'h0012});
    cw(2'h0, 2'h3, 0, 1, 2'h0, 0);
    l2(M, T, 0, 0);
    cw(2'h1, 2'h1, 0, 1, 2'h0, 0);
    l2(~M, T, 0, 1);
    l2(M, 16'h0800, 0, 0);
    cw(2'h1, 2'h1, 0, 0, 2'h0, 0);
    l2(M, T, 0, 0);
    l2(M, 16'h0800, 0, 1);
    cw(2'h1, 2'h2, 0, 1, 2'h0, 0);
    l2(M, 16'h0800, 0, 1);
    cw(2'h1, 2'h2, 1, 1, 2'h0, 0);
    l2(M, T, 0, 0);
    l2(~M, T, 0, 1);
    cw(2'h1, 2'h3, 0, 1, 2'h0, 0);
    l2(M, 16'h0800, 0, 0);
    l2(M, T, 0, 1);
    wr(6'h03, 32'hC0A8_0105);
    wr(6'h04, 32'h0000_00FF);
    cw(2'h2, 2'h1, 0, 1, 2'h0, 0);
    l3(32'hC0A8_01AA, 1);
    l3(32'hC0A9_0105, 0);
    cw(2'h2, 2'h1, 1, 1, 2'h0, 0);
    l3(32'h3F57_FEFA, 1);
    wr(6'h04, 32'h3F57_FEFA);
    cw(2'h2, 2'h2, 0, 1, 2'h0, 0);
    l3(32'h3F57_FEFA, 1);
    l3(32'hC0A8_0105, 0);
    cw(2'h2, 2'h3, 0, 0, 2'h0, 0);
    l3(32'h3F57_FEFA, 0);
    wr(6'h05, 32'h0200_0100);
    wr(6'h06, 32'h0000_0112);
    cw(2'h3, 2'h0, 0, 1, 2'h0, 0);
    l4(16'h0, 8'h00, 3'b110, 1);
    l4(16'h0, 8'h00, 3'b101, 0);
    cw(2'h3, 2'h1, 0, 1, 2'h2, 0);
    l4(16'h0100, 8'h00, 3'b110, 1);
    l4(16'h0201, 8'h00, 3'b110, 0);
    cw(2'h3, 2'h1, 0, 1, 2'h3, 0);
    l4(16'h0201, 8'h00, 3'b110, 1);
    cw(2'h3, 2'h1, 0, 1, 2'h1, 0);
    l4(16'h0200, 8'h00, 3'b110, 1);
    l4(16'h0180, 8'h00, 3'b110, 0);
    cw(2'h3, 2'h2, 1, 1, 2'h2, 0);
    l4(~16'h0180, 8'h00, 3'b101, 1);
    cw(2'h3, 2'h1, 0, 1, 2'h0, 1);
    l4(16'h0, 8'h13, 3'b110, 1);
    l4(16'h0, 8'h10, 3'b110, 0);
    cw(2'h3, 2'h1, 0, 1, 2'h0, 0);
    l4(16'h0, 8'h10, 3'b110, 1);
    wr(6'h05, 32'h0140_0140);
    cw(2'h3, 2'h3, 0, 1, 2'h0, 0);
    l4(16'h0140, 8'h00, 3'b110, 1);
    l4(16'h0141, 8'h00, 3'b110, 0);
    wr(6'h07, 32'h0000_0003);
    cw(2'h1, 2'h0, 0, 1, 2'h0, 0);
    l2(M, T, 5, 1);
    repeat (150) @(posedge clk);
    rd(6'h0A, 34'h0);
    repeat (170) @(posedge clk);
    rd(6'h0A, 34'h20);
    check({33'h0, countIrq}, 34'h0);
    wr(6'h0B, 32'h0000_003F);
    repeat (2) @(posedge clk);
    check({33'h0, countIrq}, 34'h1);
    wr(6'h0A, 32'h0000_0020);
    repeat (2) @(posedge clk);
    check({33'h0, countIrq}, 34'h0);
    wr(6'h07, 32'h0000_1002);
    l2(M, T, 2, 1);
    l2(M, 16'h0800, 2, 0);
    rd(6'h0A, 34'h0);
    l2(M, T, 2, 1);
    repeat (3) @(posedge clk);
    check({33'h0, countIrq}, 34'h1);
    rd(6'h0A, 34'h4);
    repeat (3) @(posedge clk);
    endSim();
  end
endmodule // amre_acl_matching_rule_evaluator_tb
